// file: hdl/scsd_top.sv
// System clock source select, divider and internal oscillator model
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module scsd_top
  import scsd_pkg::*;
#(
  parameter logic [SCSD_TRIM_W-1:0] TRIM_RESET = 7'h40, // Factory trim value
  parameter int TRIM_STEP_INC = 64 // Increment change per trim code
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [SCSD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [SCSD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External oscillator edges, one pulse per period
  input wire logic ext_osc_tick,
  // Clock and status outputs
  output logic system_clock_tick,
  output logic internal_osc_tick,
  output logic active_source_ext,
  output logic divide_applied_flag
);

  // Write channel holding state
  logic aw_held_ff;
  logic [SCSD_ADDR_W-1:0] aw_addr_ff;
  logic w_held_ff;
  logic [7:0] w_data_ff;
  logic w_lane0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  // Read channel state
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rdata_ff;

  // Software-visible fields
  logic [2:0] src_field_ff; // Requested source
  logic [2:0] div_field_ff; // Requested divide exponent
  logic osc_en_ff; // Internal oscillator enable
  logic spread_en_ff; // Spread spectrum enable
  logic [1:0] post_scale_ff; // Internal post-scale code
  logic [SCSD_TRIM_W-1:0] trim_ff; // Oscillator trim

  // Clock generation state
  logic [SCSD_ACC_W-1:0] acc_ff; // Oscillator phase accumulator
  logic osc_tick_ff; // Raw internal oscillator edge
  logic [4:0] ss_cyc_ff; // Oscillator cycles within a spread step
  logic [3:0] ss_phase_ff; // Step index along the triangle
  logic [2:0] ps_cnt_ff; // Post-scaler count
  logic int_tick_ff; // Post-scaled internal edge
  logic src_ext_ff; // Source in use
  scsd_switch_type sw_state_ff;
  logic [SCSD_DCNT_W-1:0] dcnt_ff; // Source edges within one output period
  logic [2:0] div_act_ff; // Divide exponent in use
  logic pending_ff; // New divide not yet in use
  logic sys_tick_ff;

  // Bus decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held_ff && w_held_ff;
  wire wr_sel = do_write && w_lane0_ff && (aw_addr_ff == SCSD_ADDR_SEL);
  wire wr_ctl = do_write && w_lane0_ff && (aw_addr_ff == SCSD_ADDR_CTL);
  wire wr_trim = do_write && w_lane0_ff && (aw_addr_ff == SCSD_ADDR_TRIM);
  wire wr_hit = (aw_addr_ff == SCSD_ADDR_SEL) || (aw_addr_ff == SCSD_ADDR_CTL) ||
                (aw_addr_ff == SCSD_ADDR_TRIM);
  wire rd_hit_sel = s_axi_araddr == SCSD_ADDR_SEL;
  wire rd_hit_ctl = s_axi_araddr == SCSD_ADDR_CTL;
  wire rd_hit_trim = s_axi_araddr == SCSD_ADDR_TRIM;
  wire rd_hit = rd_hit_sel || rd_hit_ctl || rd_hit_trim;

  // New field values from the held write data
  wire [2:0] wr_div = w_data_ff[SCSD_SEL_DIV_LSB +: 3];
  wire [2:0] wr_src = w_data_ff[SCSD_SEL_SRC_LSB +: 3];
  wire div_change = wr_sel && (wr_div != div_field_ff);

  // Register read images; unused bits read zero
  wire [7:0] sel_image = {~pending_ff, div_field_ff, 1'b0, src_field_ff};
  wire [7:0] ctl_image = {osc_en_ff, osc_en_ff, 2'h0, spread_en_ff, 1'b0, post_scale_ff};
  wire [7:0] trim_image = {1'b0, trim_ff};
  wire [7:0] rd_image = rd_hit_sel ? sel_image :
                        rd_hit_ctl ? ctl_image :
                        rd_hit_trim ? trim_image : 8'h00;

  // Channel readiness; one write and one read in flight at most
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h0, rdata_ff};

  // Write address capture; released once the write is carried out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (aw_take) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  // Write data capture; only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (w_take) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response, error for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= SCSD_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? SCSD_RESP_OKAY : SCSD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read answer, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= SCSD_RESP_OKAY;
      rdata_ff <= 8'h00;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? SCSD_RESP_OKAY : SCSD_RESP_SLVERR;
      rdata_ff <= rd_image;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Select register; reset returns the internal oscillator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_field_ff <= SCSD_SRC_INT;
      div_field_ff <= SCSD_DIV_RESET;
    end else if (wr_sel) begin
      src_field_ff <= wr_src;
      div_field_ff <= wr_div;
    end
  end

  // Oscillator control and trim registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_en_ff <= 1'b1;
      spread_en_ff <= 1'b0;
      post_scale_ff <= SCSD_PS_RESET;
      trim_ff <= TRIM_RESET;
    end else begin
      if (wr_ctl) begin
        osc_en_ff <= w_data_ff[SCSD_CTL_EN_BIT];
        spread_en_ff <= w_data_ff[SCSD_CTL_SPREAD_BIT];
        post_scale_ff <= w_data_ff[SCSD_CTL_PS_LSB +: 2];
      end
      if (wr_trim) begin
        trim_ff <= w_data_ff[SCSD_TRIM_W-1:0];
      end
    end
  end

  // Triangle level from step index: 0,1,2,3,2,1,0,-1,-2,-3,-2,-1
  wire signed [3:0] phase_s = signed'(ss_phase_ff);
  wire signed [3:0] ss_level = (ss_phase_ff <= 4'd3) ? phase_s :
                               (ss_phase_ff <= 4'd9) ? 4'sd6 - phase_s :
                               phase_s + 4'sd4;

  // Accumulator increment: higher trim lowers frequency
  localparam logic signed [19:0] INC_C = 20'(SCSD_INC_CENTER);
  localparam logic signed [19:0] SS_ST = 20'(SCSD_SS_STEP);
  localparam logic signed [19:0] TR_ST = 20'(TRIM_STEP_INC);
  wire signed [19:0] trim_off = 20'(signed'({1'b0, TRIM_RESET})) -
                                20'(signed'({1'b0, trim_ff}));
  wire signed [19:0] ss_off = spread_en_ff ? 20'(ss_level) * SS_ST : 20'sd0;
  wire signed [19:0] inc_s = INC_C + trim_off * TR_ST + ss_off;
  wire [SCSD_ACC_W:0] acc_sum = {1'b0, acc_ff} + inc_s[SCSD_ACC_W:0];

  // Oscillator edge on accumulator carry, stopped when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= '0;
      osc_tick_ff <= 1'b0;
    end else if (osc_en_ff) begin
      acc_ff <= acc_sum[SCSD_ACC_W-1:0];
      osc_tick_ff <= acc_sum[SCSD_ACC_W];
    end else begin
      osc_tick_ff <= 1'b0;
    end
  end

  // Spread stepping: a step per 32 edges, twelve steps per sweep
  localparam logic [4:0] SS_LAST_CYC = 5'(SCSD_SS_CYCLES - 1);
  localparam logic [3:0] SS_LAST_PH = 4'(SCSD_SS_PHASES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || !spread_en_ff) begin
      ss_cyc_ff <= 5'h0;
      ss_phase_ff <= 4'h0;
    end else if (osc_tick_ff) begin
      ss_cyc_ff <= ss_cyc_ff + 5'h1;
      if (ss_cyc_ff == SS_LAST_CYC) begin
        ss_phase_ff <= (ss_phase_ff == SS_LAST_PH) ? 4'h0 : ss_phase_ff + 4'h1;
      end
    end
  end

  // Post-scaler: code 00 divides by 8, code 11 by 1
  wire [1:0] ps_exp = SCSD_PS_MAX_EXP - post_scale_ff;
  wire [2:0] ps_last = 3'((4'h1 << ps_exp) - 4'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_cnt_ff <= 3'h0;
      int_tick_ff <= 1'b0;
    end else if (osc_tick_ff) begin
      ps_cnt_ff <= (ps_cnt_ff >= ps_last) ? 3'h0 : ps_cnt_ff + 3'h1;
      int_tick_ff <= ps_cnt_ff >= ps_last;
    end else begin
      int_tick_ff <= 1'b0;
    end
  end

  // Source request; reserved codes fall back on the internal oscillator
  wire want_ext = src_field_ff == SCSD_SRC_EXT;
  wire old_tick = src_ext_ff ? ext_osc_tick : int_tick_ff;
  wire new_tick = src_ext_ff ? int_tick_ff : ext_osc_tick;

  // Switchover: an edge of the old source, then one of the new
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state_ff <= SCSD_SW_IDLE;
      src_ext_ff <= 1'b0;
    end else begin
      case (sw_state_ff)
        SCSD_SW_IDLE: begin
          if (want_ext != src_ext_ff) begin
            sw_state_ff <= SCSD_SW_WAIT_OLD;
          end
        end
        SCSD_SW_WAIT_OLD: begin
          if (want_ext == src_ext_ff) begin
            sw_state_ff <= SCSD_SW_IDLE;
          end else if (old_tick) begin
            sw_state_ff <= SCSD_SW_WAIT_NEW;
          end
        end
        SCSD_SW_WAIT_NEW: begin
          if (want_ext == src_ext_ff) begin
            sw_state_ff <= SCSD_SW_IDLE;
          end else if (new_tick) begin
            src_ext_ff <= want_ext;
            sw_state_ff <= SCSD_SW_IDLE;
          end
        end
        default: begin
          sw_state_ff <= SCSD_SW_IDLE;
        end
      endcase
    end
  end

  // Undivided source edge; held off while switching to avoid runt periods
  wire src_tick = (sw_state_ff == SCSD_SW_IDLE) && old_tick;

  // Output divider; a new exponent is taken only at a period boundary,
  // so the change lands within 128 source edges
  wire [SCSD_DCNT_W-1:0] d_last = SCSD_DCNT_W'((8'h01 << div_act_ff) - 8'h01);
  wire boundary = src_tick && (dcnt_ff >= d_last);
  wire apply = boundary && pending_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcnt_ff <= '0;
      div_act_ff <= SCSD_DIV_RESET;
      sys_tick_ff <= 1'b0;
    end else begin
      sys_tick_ff <= boundary;
      if (boundary) begin
        dcnt_ff <= '0;
      end else if (src_tick) begin
        dcnt_ff <= dcnt_ff + 1'b1;
      end
      if (apply) begin
        div_act_ff <= div_field_ff;
      end
    end
  end

  // Pending flag; a changing write wins over an apply in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_ff <= 1'b1;
    end else if (div_change) begin
      pending_ff <= 1'b1;
    end else if (apply) begin
      pending_ff <= 1'b0;
    end
  end

  // Outputs
  assign system_clock_tick = sys_tick_ff;
  assign internal_osc_tick = int_tick_ff;
  assign active_source_ext = src_ext_ff;
  assign divide_applied_flag = !pending_ff;

endmodule // scsd_top

// file: hdl/scsd_pkg.sv
// Constants and types for the system clock select and divide block
package scsd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] SCSD_IDX_SEL = 8'ha9;
  localparam logic [7:0] SCSD_IDX_CTL = 8'hb2;
  localparam logic [7:0] SCSD_IDX_TRIM = 8'hb3;
  localparam int SCSD_ADDR_W = 12;
  localparam logic [11:0] SCSD_ADDR_SEL = {2'h0, SCSD_IDX_SEL, 2'h0};
  localparam logic [11:0] SCSD_ADDR_CTL = {2'h0, SCSD_IDX_CTL, 2'h0};
  localparam logic [11:0] SCSD_ADDR_TRIM = {2'h0, SCSD_IDX_TRIM, 2'h0};
  // Select register fields
  localparam int SCSD_SEL_RDY_BIT = 7;
  localparam int SCSD_SEL_DIV_LSB = 4;
  localparam int SCSD_SEL_SRC_LSB = 0;
  localparam logic [2:0] SCSD_SRC_INT = 3'h0;
  localparam logic [2:0] SCSD_SRC_EXT = 3'h1;
  localparam logic [2:0] SCSD_DIV_RESET = 3'h0;
  // Internal oscillator control fields
  localparam int SCSD_CTL_EN_BIT = 7;
  localparam int SCSD_CTL_FRDY_BIT = 6;
  localparam int SCSD_CTL_SPREAD_BIT = 3;
  localparam int SCSD_CTL_PS_LSB = 0;
  localparam logic [1:0] SCSD_PS_RESET = 2'h0;
  localparam logic [1:0] SCSD_PS_MAX_EXP = 2'h3;
  // Trim field
  localparam int SCSD_TRIM_W = 7;
  // Oscillator model, phase accumulator at the bus clock
  localparam longint SCSD_CLK_HZ = 100_000_000;
  localparam longint SCSD_OSC_HZ = 24_500_000;
  localparam int SCSD_ACC_W = 16;
  localparam longint SCSD_INC_CENTER = (SCSD_OSC_HZ << SCSD_ACC_W) / SCSD_CLK_HZ;
  localparam longint SCSD_SS_STEP = SCSD_INC_CENTER * 25 / 10000;
  localparam int SCSD_SS_CYCLES = 32;
  localparam int SCSD_SS_PERIOD = 384;
  localparam int SCSD_SS_PHASES = SCSD_SS_PERIOD / SCSD_SS_CYCLES;
  // Divider
  localparam int SCSD_DCNT_W = 7;
  // Bus answers
  localparam logic [1:0] SCSD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCSD_RESP_SLVERR = 2'h2;
  // Source switchover sequence
  typedef enum logic [1:0] {
    SCSD_SW_IDLE,
    SCSD_SW_WAIT_OLD,
    SCSD_SW_WAIT_NEW
  } scsd_switch_type;
endpackage

// file: testbench/scsd_props.sv
// Port checker for the clock select and divide block
`timescale 1ns/1ps
module scsd_props
  import scsd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Clock side
  input wire logic ext_osc_tick,
  input wire logic system_clock_tick,
  input wire logic internal_osc_tick,
  input wire logic active_source_ext,
  input wire logic divide_applied_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles spent with the divide still pending
  logic [13:0] low_cnt_ff;
  logic [13:0] nxt_low_cnt;
  assign nxt_low_cnt = divide_applied_flag ? 14'h0 : low_cnt_ff + 14'h1;
  // Counter kept short so the bound stays a plain compare
  always_ff @(posedge aclk) begin
    if (!aresetn) low_cnt_ff <= 14'h0;
    else low_cnt_ff <= nxt_low_cnt;
  end
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  flag_clear_a: assert property ($fell(divide_applied_flag) |-> s_axi_bvalid)
    else $error("flag fell without a write");
  divide_bound_a: assert property (low_cnt_ff < 14'h1f40)
    else $error("divide change too slow");
  osc_pulse_a: assert property (internal_osc_tick |=> !internal_osc_tick)
    else $error("oscillator pulse too long");
  reset_source_a: assert property ($rose(aresetn) |-> !active_source_ext)
    else $error("reset left external source");
  ext_tick_a: assert property (active_source_ext && $past(active_source_ext) &&
    system_clock_tick |-> $past(ext_osc_tick)) else $error("tick not from ext");
  int_tick_a: assert property (!active_source_ext && !$past(active_source_ext) &&
    system_clock_tick |-> $past(internal_osc_tick)) else $error("tick not from osc");
  cover property ($rose(active_source_ext));
  cover property ($fell(divide_applied_flag));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // scsd_props

// file: testbench/tb_system_clock_select_divider.sv
// Self-checking bench for the clock select and divide block
`timescale 1ns/1ps
module tb_system_clock_select_divider;
  import scsd_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic arv = 1'b0, rready = 1'b0, ext_osc_tick = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, sys_tick, osc_tick, src_ext, flag;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] ext_cnt = 3'h0; // External tick every fifth cycle
  int n_mismatch = 0, check_count = 0;
  logic [31:0] d;
  logic [1:0] r;
  int ni, ns, ne, c[4], base;
  scsd_top u_scsd_top (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_osc_tick,
    .system_clock_tick(sys_tick), .internal_osc_tick(osc_tick),
    .active_source_ext(src_ext), .divide_applied_flag(flag));
  always #5 aclk = ~aclk;
  // External source keeps running so a pending divide always completes
  always @(posedge aclk) begin
    ext_cnt <= (ext_cnt == 3'h4) ? 3'h0 : ext_cnt + 3'h1;
    ext_osc_tick <= (ext_cnt == 3'h4);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write holds each channel until its own ready, then waits for the answer;
  // a nonzero lag lets the answer stand that many cycles before bready rises
  task wr(input logic [11:0] a, input logic [7:0] v, input int lag = 0);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, v}; wstrb <= 4'hf; awv <= 1'b1; wv <= 1'b1;
    bready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid && bready) begin
        r = bresp; bready <= 1'b0; break;
      end
      if (bvalid) lag--;
      if (bvalid && lag <= 0) bready <= 1'b1;
    end
  endtask
  // Read with the same optional lag on rready
  task rd(input logic [11:0] a, input int lag = 0);
    @(posedge aclk);
    araddr <= a; arv <= 1'b1; rready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      if (rvalid && rready) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
      if (rvalid) lag--;
      if (rvalid && lag <= 0) rready <= 1'b1;
    end
  endtask
  // Counts oscillator, system and external ticks over a window
  task cnt(input int w);
    ni = 0; ns = 0; ne = 0;
    repeat (w) begin
      @(posedge aclk);
      ni += (osc_tick === 1'b1); ns += (sys_tick === 1'b1); ne += (ext_osc_tick === 1'b1);
    end
  endtask
  // Bounded wait; a flag that never settles counts as a mismatch
  task wait_val(input bit s, input logic v);
    int k;
    for (k = 0; k < 9000 && (s ? src_ext : flag) !== v; k++) @(posedge aclk);
    chk(s ? src_ext : flag, v);
  endtask
  task t_reset;
    rd(SCSD_ADDR_SEL); chk(d & 32'h7f, 32'h0);
    rd(SCSD_ADDR_CTL); chk(d, 32'hc0);
    rd(SCSD_ADDR_TRIM); chk(d, 32'h40);
    chk(r, SCSD_RESP_OKAY);
    rd(12'h000); chk(r, SCSD_RESP_SLVERR); chk(d, 32'h0);
    wr(12'h000, 8'h55); chk(r, SCSD_RESP_SLVERR);
  endtask
  task t_scale;
    for (int p = 0; p < 4; p++) begin
      wr(SCSD_ADDR_CTL, 8'h80 | p[7:0]);
      cnt(2000); c[p] = ni;
    end
    rd(SCSD_ADDR_CTL); chk(d, 32'hc3);
    for (int p = 0; p < 3; p++) chk((c[p] << (3 - p)) + 12 > c[3] && c[3] + 12 > (c[p] << (3 - p)), 1);
  endtask
  task t_div;
    wr(SCSD_ADDR_SEL, 8'h30); wait_val(0, 1'b1);
    rd(SCSD_ADDR_SEL); chk(d, 32'hb0);
    cnt(2000); chk(ns * 8 + 9 > ni && ni + 9 > ns * 8, 1);
    while (sys_tick !== 1'b1) @(posedge aclk);
    wr(SCSD_ADDR_SEL, 8'h70); chk(flag, 1'b0);
    wait_val(0, 1'b1);
    wr(SCSD_ADDR_SEL, 8'h70); chk(flag, 1'b1);
  endtask
  task t_ext;
    wr(SCSD_ADDR_SEL, 8'h71); wait_val(1, 1'b1); wait_val(0, 1'b1);
    cnt(6400); chk(ns * 128 + 129 > ne && ne + 129 > ns * 128, 1);
    wr(SCSD_ADDR_SEL, 8'h00); wait_val(1, 1'b0);
    rd(SCSD_ADDR_SEL); chk(d & 32'h7f, 32'h0);
  endtask
  task t_trim;
    wr(SCSD_ADDR_TRIM, 8'h00); cnt(2000); base = ni;
    wr(SCSD_ADDR_TRIM, 8'hff, 3); chk(r, SCSD_RESP_OKAY);
    rd(SCSD_ADDR_TRIM, 3); chk(d, 32'h7f);
    cnt(2000); chk(base > ni, 1);
    wr(SCSD_ADDR_TRIM, 8'h40);
  endtask
  task t_spread;
    cnt(3135); base = ni;
    wr(SCSD_ADDR_CTL, 8'h8b); rd(SCSD_ADDR_CTL); chk(d, 32'hcb);
    cnt(3135); chk(ni + 12 > base && base + 12 > ni, 1);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog set well above the expected run of some twenty-seven thousand cycles
  initial begin
    #800000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset; t_scale; t_div; t_ext; t_trim; t_spread;
    give_verdict;
  end
endmodule // tb_system_clock_select_divider
bind scsd_top scsd_props u_scsd_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .ext_osc_tick, .system_clock_tick, .internal_osc_tick, .active_source_ext,
  .divide_applied_flag);
